//--- sport_defines.svh
// Purpose: Constants for the serial register access port, both ends.
// Assumes: Included by the package and by both end modules.
// Notes: Timing counts are in cycles of the 200 MHz system clock.
`ifndef SPORT_DEFINES_SVH
`define SPORT_DEFINES_SVH
`define SP_INSTR_BITS 5
`define SP_ADDR_BITS 11
`define SP_DATA_BITS 8
`define SP_HDR_BITS 16
`define SP_CLK_MHZ 200
`define SP_SCLK_HALF_NS 250
`define SP_SCLK_HALF_CYC ((`SP_SCLK_HALF_NS * `SP_CLK_MHZ) / 1000)
`define SP_CSH_NS 100
`define SP_CSH_CYC ((`SP_CSH_NS * `SP_CLK_MHZ + 999) / 1000)
`define SP_READ_CODE 5'h10
`define SP_WRITE_CODE 5'h00
`endif

//--- sport_pkg.sv
// Purpose: Types shared by the serial register access port ends.
// Assumes: The defines header is on the include path.
// Notes: Holds state types only; numbers live in the header.
`include "sport_defines.svh"
package sport_pkg;
  typedef enum {DEV_IDLE, DEV_HDR, DEV_WDATA, DEV_RDATA, DEV_DONE} dev_state_t;
  typedef enum {HST_IDLE, HST_LOW, HST_HIGH, HST_END, HST_GAP} hst_state_t;
endpackage

//--- sport_if.sv
// Purpose: Serial link between host and device ends.
// Assumes: Host resolves the data output wire from its enable.
// Notes: No clocking block; plain wires.
`timescale 1ns/100ps
interface sport_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  modport device (input cs_n, input sclk, input sdi, output sdo, output sdo_oe);
  modport host (output cs_n, output sclk, output sdi, input sdo, input sdo_oe);
endinterface

//--- sport_device.sv
// Purpose: Device end: decodes serial frames, holds register storage.
// Assumes: Link pins are asynchronous and sampled by CLK.
// Notes: Register array is small; depth is its own parameter (DEPTH, 64), not the address width.
//   Every link pin crosses two flip-flops, so a frame edge is seen about three cycles late.
//   The serial clock must stay well below a quarter of CLK; 2 MHz leaves ample margin.
`timescale 1ns/100ps
`include "sport_defines.svh"
module sport_device
  import sport_pkg::*;
#(
  parameter int AW = `SP_ADDR_BITS,
  parameter int DW = `SP_DATA_BITS,
  parameter int DEPTH = 64
) (
  input wire logic CLK,
  input wire logic RST,
  sport_if.device LINK,
  output logic WR_STB,
  output logic [AW-1:0] WR_ADDR,
  output logic [DW-1:0] WR_DATA,
  output logic BUSY
);
  // Pin order in the synchroniser bank: select, serial clock, data in.
  localparam int NPIN = 3;
  localparam logic [NPIN-1:0] PIN_IDLE = 3'h1;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  logic cs_s, sclk_s, sdi_s;
  logic cs_d_reg, sclk_d_reg;

  // Sequencer, shift and write-port registers with their next values.
  dev_state_t state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [15:0] hdr_reg, hdr_next;
  logic [DW-1:0] sh_reg, sh_next;
  logic oe_reg, oe_next;
  logic sdo_reg, sdo_next;
  logic wstb_reg, wstb_next;
  logic [AW-1:0] waddr_reg, waddr_next;
  logic [DW-1:0] wdata_reg, wdata_next;

  // Storage, one byte per mapped address.
  logic [DW-1:0] mem [DEPTH];
  // Decoded edges and level of the synchronised pins.
  logic cs_fall, cs_rise, sclk_rise, sclk_fall, cs_low;

  // Two-stage synchronisers, one per link pin; only the second stage feeds logic.
  assign pin_raw = {LINK.sdi, LINK.sclk, LINK.cs_n};
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge CLK) begin
      if (RST) begin
        pin_meta_reg[i] <= PIN_IDLE[i];
        pin_sync_reg[i] <= PIN_IDLE[i];
      end else begin
        pin_meta_reg[i] <= pin_raw[i];
        pin_sync_reg[i] <= pin_meta_reg[i];
      end
    end
  end
  assign cs_s = pin_sync_reg[0];
  assign sclk_s = pin_sync_reg[1];
  assign sdi_s = pin_sync_reg[2];

  // Delayed copies reset to the idle pin levels, so no false edge follows reset.
  always_ff @(posedge CLK) begin
    if (RST) begin
      cs_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      cs_d_reg <= cs_s;
      sclk_d_reg <= sclk_s;
    end
  end

  // Edge detection on the synchronised select and serial clock.
  assign cs_low = ~cs_s;
  assign cs_fall = cs_d_reg & ~cs_s;
  assign cs_rise = ~cs_d_reg & cs_s;
  assign sclk_rise = ~sclk_d_reg & sclk_s;
  assign sclk_fall = sclk_d_reg & ~sclk_s;

  // Address decode shared by the read mux and the storage write.
  function automatic logic addr_hit(input logic [AW-1:0] a);
    addr_hit = (a < AW'(DEPTH));
  endfunction

  // Reads return zero outside the storage so a stray address is harmless.
  function automatic logic [DW-1:0] rd_word(input logic [AW-1:0] a);
    rd_word = addr_hit(a) ? mem[a[$clog2(DEPTH)-1:0]] : '0;
  endfunction

  // Frame sequencer: header, then a data byte in or out.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hdr_next = hdr_reg;
    sh_next = sh_reg;
    oe_next = oe_reg;
    sdo_next = sdo_reg;
    wstb_next = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    // A deselected port returns to idle and drops its output enable, so a cut frame leaves no trace.
    if (cs_rise || !cs_low) begin
      state_next = DEV_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        // Only a select fall opens a frame; a select held low through reset reads as one, since the select synchroniser resets high.
        DEV_IDLE: begin
          if (cs_fall) begin
            state_next = DEV_HDR;
            cnt_next = 5'h00;
          end
        end
        // Instruction and address share one 16-bit shift register.
        DEV_HDR: begin
          if (sclk_rise) begin
            hdr_next = {hdr_reg[14:0], sdi_s};
            cnt_next = cnt_reg + 5'h01;
            // On the last header bit the instruction's top bit sits at position 14.
            if (cnt_reg == 5'(`SP_HDR_BITS - 1)) begin
              cnt_next = 5'h00;
              if (hdr_reg[14]) begin
                state_next = DEV_RDATA;
                sh_next = rd_word(AW'({hdr_reg[9:0], sdi_s}));
              end else begin
                state_next = DEV_WDATA;
              end
            end
          end
        end
        // Each serial fall puts out the next bit; the rise after the eighth ends it.
        DEV_RDATA: begin
          if (sclk_fall) begin
            oe_next = 1'b1;
            sdo_next = sh_reg[DW-1];
            sh_next = {sh_reg[DW-2:0], 1'b0};
            cnt_next = cnt_reg + 5'h01;
          end else if (sclk_rise && cnt_reg == 5'(DW)) begin
            state_next = DEV_DONE;
          end
        end
        // The strobe is raised only when the whole byte has arrived.
        DEV_WDATA: begin
          if (sclk_rise) begin
            sh_next = {sh_reg[DW-2:0], sdi_s};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == 5'(DW - 1)) begin
              wstb_next = 1'b1;
              waddr_next = AW'(hdr_reg[10:0]);
              wdata_next = {sh_reg[DW-2:0], sdi_s};
              state_next = DEV_DONE;
            end
          end
        end
        // Extra clocks after the byte are ignored until select rises.
        DEV_DONE: begin
          if (sclk_fall) begin
            oe_next = 1'b0;
          end
        end
        // An illegal state falls back to waiting for a select edge.
        default: state_next = DEV_IDLE;
      endcase
    end
  end

  // Register the sequencer state.
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= DEV_IDLE;
      cnt_reg <= 5'h00;
      hdr_reg <= 16'h0000;
      sh_reg <= '0;
      oe_reg <= 1'b0;
      sdo_reg <= 1'b0;
      wstb_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hdr_reg <= hdr_next;
      sh_reg <= sh_next;
      oe_reg <= oe_next;
      sdo_reg <= sdo_next;
      wstb_reg <= wstb_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  // Storage is written one cycle after the last data bit lands.
  always_ff @(posedge CLK) begin
    if (wstb_reg && addr_hit(waddr_reg)) begin
      mem[waddr_reg[$clog2(DEPTH)-1:0]] <= wdata_reg;
    end
  end

  // Link and write-port outputs come straight from flip-flops; BUSY is decoded.
  assign LINK.sdo = sdo_reg;
  assign LINK.sdo_oe = oe_reg;
  assign WR_STB = wstb_reg;
  assign WR_ADDR = waddr_reg;
  assign WR_DATA = wdata_reg;
  assign BUSY = (state_reg != DEV_IDLE);
endmodule // sport_device

//--- sport_host.sv
// Purpose: Host end: runs one read or write frame per request.
// Assumes: Serial clock derived here by a divider from CLK.
// Notes: Read data is sampled on the rising edge after the device shifts it.
`timescale 1ns/100ps
`include "sport_defines.svh"
module sport_host
  import sport_pkg::*;
#(
  parameter int AW = `SP_ADDR_BITS,
  parameter int DW = `SP_DATA_BITS,
  parameter int HALF = `SP_SCLK_HALF_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  sport_if.host LINK,
  input wire logic REQ,
  input wire logic RD,
  input wire logic [AW-1:0] ADDR,
  input wire logic [DW-1:0] WDATA,
  output logic READY,
  output logic DONE,
  output logic [DW-1:0] RDATA
);
  localparam int NB = `SP_HDR_BITS + DW;
  hst_state_t state_reg, state_next;
  logic [15:0] tmr_reg, tmr_next;
  logic [5:0] bit_reg, bit_next;
  logic [NB-1:0] sh_reg, sh_next;
  logic [DW-1:0] rd_reg, rd_next;
  logic cs_reg, cs_next, sclk_reg, sclk_next, sdi_reg, sdi_next, done_reg, done_next;
  logic [1:0] sdo_sync_reg;
  logic [1:0] oe_sync_reg;

  // Read data comes from the other party, so it is synchronised.
  always_ff @(posedge CLK) begin
    if (RST) begin
      sdo_sync_reg <= 2'h0;
      oe_sync_reg <= 2'h0;
    end else begin
      sdo_sync_reg <= {sdo_sync_reg[0], LINK.sdo};
      oe_sync_reg <= {oe_sync_reg[0], LINK.sdo_oe};
    end
  end

  // Frame generator; each serial half period lasts HALF+1 cycles.
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    rd_next = rd_reg;
    cs_next = cs_reg;
    sclk_next = sclk_reg;
    sdi_next = sdi_reg;
    done_next = 1'b0;
    if (tmr_reg != 16'h0000) begin
      tmr_next = tmr_reg - 16'h0001;
    end else begin
      case (state_reg)
        HST_IDLE: begin
          if (REQ) begin
            cs_next = 1'b0;
            sh_next = {(RD ? `SP_READ_CODE : `SP_WRITE_CODE), ADDR, WDATA};
            sdi_next = RD;
            bit_next = 6'h00;
            tmr_next = 16'(HALF);
            state_next = HST_LOW;
          end
        end
        HST_LOW: begin
          sclk_next = 1'b1;
          // The first data bit is driven on the fall that ends the header, so bit 16 is sampled.
          if (bit_reg >= 6'(`SP_HDR_BITS)) begin
            // An undriven line reads as one, as if held by a pull-up.
            rd_next = {rd_reg[DW-2:0], (oe_sync_reg[1] ? sdo_sync_reg[1] : 1'b1)};
          end
          tmr_next = 16'(HALF);
          state_next = HST_HIGH;
        end
        HST_HIGH: begin
          sclk_next = 1'b0;
          sh_next = {sh_reg[NB-2:0], 1'b0};
          sdi_next = sh_reg[NB-2];
          bit_next = bit_reg + 6'h01;
          tmr_next = 16'(HALF);
          state_next = (bit_reg == 6'(NB - 1)) ? HST_END : HST_LOW;
        end
        HST_END: begin
          cs_next = 1'b1;
          done_next = 1'b1;
          tmr_next = 16'(`SP_CSH_CYC);
          state_next = HST_GAP;
        end
        HST_GAP: state_next = HST_IDLE;
        default: state_next = HST_IDLE;
      endcase
    end
  end

  // Register the generator state.
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= HST_IDLE;
      tmr_reg <= 16'h0000;
      bit_reg <= 6'h00;
      sh_reg <= '0;
      rd_reg <= '0;
      cs_reg <= 1'b1;
      sclk_reg <= 1'b0;
      sdi_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      rd_reg <= rd_next;
      cs_reg <= cs_next;
      sclk_reg <= sclk_next;
      sdi_reg <= sdi_next;
      done_reg <= done_next;
    end
  end

  assign LINK.cs_n = cs_reg;
  assign LINK.sclk = sclk_reg;
  assign LINK.sdi = sdi_reg;
  assign READY = (state_reg == HST_IDLE) && (tmr_reg == 16'h0000);
  assign DONE = done_reg;
  assign RDATA = rd_reg;
endmodule // sport_host

//--- sport_props.sv
// Purpose: Protocol checks on the link joining host and device ends.
// Assumes: Link pins are sampled by the 200 MHz CLK; serial clock idles low.
// Notes: The bit count is rebuilt here so frame length is judged on its own.
`timescale 1ns/100ps
module sport_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic [4:0] cnt_reg, cnt_next;
  logic sclk_reg, rd_reg, rd_next;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Count serial rising edges in a frame; the first one carries the read flag.
  always_comb begin
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    if (cs_n) begin
      cnt_next = 5'h00;
    end else if (sclk && !sclk_reg) begin
      cnt_next = cnt_reg + 5'h01;
      if (cnt_reg == 5'h00) begin
        rd_next = sdi;
      end
    end
  end
  // Registers only; reset clears them so a new run starts counting from zero.
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_reg <= 5'h00;
      sclk_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sclk_reg <= sclk;
      rd_reg <= rd_next;
    end
  end
  property p_idle_clk; cs_n |-> !sclk; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock moved while deselected");
  property p_setup; $fell(cs_n) |-> !sclk [*4]; endproperty
  a_setup: assert property (p_setup) else $error("clock rose too soon after select");
  property p_hold; !cs_n && sclk && $past(sclk) |-> $stable(sdi); endproperty
  a_hold: assert property (p_hold) else $error("input data moved while clock high");
  property p_frame_len; $rose(cs_n) |-> cnt_reg == 5'h18; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 24 bits");
  property p_oe_read; sdo_oe && !cs_n |-> rd_reg && cnt_reg >= 5'h10; endproperty
  a_oe_read: assert property (p_oe_read) else $error("output driven outside read data");
  property p_oe_release; cs_n [*5] |-> !sdo_oe; endproperty
  a_oe_release: assert property (p_oe_release) else $error("output driven while deselected");
  property p_sdo_fall; sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sclk; endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("output changed with clock high");
  property p_cs_high; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_cs_high: assert property (p_cs_high) else $error("select high time too short");
  c_read: cover property ($rose(sdo_oe));
  c_frame: cover property ($rose(cs_n));
  c_write: cover property ($rose(cs_n) && !rd_reg);
endmodule // sport_props

//--- tb_serial_register_access_port.sv
// Purpose: Self-checking bench for the host and device ends of the port.
// Assumes: HALF is cut to 8, so one serial bit takes 18 system clocks.
// Notes: A second device on its own link is driven by hand to abort a frame.
`timescale 1ns/100ps
module tb_serial_register_access_port;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic req = 1'b0;
  logic rd = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [10:0] wa, wa2, sa, sa2;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, q, wd, wd2, sd, sd2;
  logic ready, done, stb, stb2, busy, busy2;
  int bad_count = 0;
  int total_checks = 0;
  int n1 = 0;
  int n2 = 0;
  sport_if link();
  sport_if link2();
  always #2.5 CLK = ~CLK;
  sport_host #(.HALF(8)) sport_host_i (.CLK(CLK), .RST(RST), .LINK(link.host), .REQ(req), .RD(rd),
    .ADDR(addr), .WDATA(wdata), .READY(ready), .DONE(done), .RDATA(rdata));
  sport_device sport_device_i (.CLK(CLK), .RST(RST), .LINK(link.device), .WR_STB(stb), .WR_ADDR(wa),
    .WR_DATA(wd), .BUSY(busy));
  if (1) begin : abort_side
    sport_device sport_device_i (.CLK(CLK), .RST(RST), .LINK(link2.device), .WR_STB(stb2),
      .WR_ADDR(wa2), .WR_DATA(wd2), .BUSY(busy2));
  end
  sport_props sport_props_i (.CLK(CLK), .RST(RST), .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi),
    .sdo(link.sdo), .sdo_oe(link.sdo_oe));
  // Latch each committed write, since the strobe lasts only one cycle.
  always @(negedge CLK) begin
    if (stb === 1'b1) begin
      n1++;
      sa = wa;
      sd = wd;
    end
    if (stb2 === 1'b1) begin
      n2++;
      sa2 = wa2;
      sd2 = wd2;
    end
  end
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_n(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask
  // One host frame; the request is held until an edge that sees READY high.
  task automatic host_op(input logic r, input logic [10:0] a, input logic [7:0] d);
    int k;
    @(negedge CLK);
    req = 1'b1;
    rd = r;
    addr = a;
    wdata = d;
    k = 0;
    while (ready !== 1'b1 && k < 1000) begin
      @(negedge CLK);
      k++;
    end
    @(negedge CLK);
    req = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 1000) begin
      @(negedge CLK);
      k++;
    end
    chk_n("host done", 1, (k < 1000) ? 1 : 0);
    q = rdata;
  endtask
  // Shift n bits MSB first at an 80 ns bit period; the line is then left inverted.
  task automatic bang(input logic [23:0] v, input int n);
    link2.cs_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      link2.sdi = v[i];
      repeat (8) @(negedge CLK);
      link2.sclk = 1'b1;
      repeat (8) @(negedge CLK);
      link2.sclk = 1'b0;
    end
    repeat (8) @(negedge CLK);
    chk("busy in frame", 11'h001, {10'h000, busy2});
    link2.cs_n = 1'b1;
    link2.sdi = ~link2.sdi;
    repeat (40) @(negedge CLK);
    chk("busy after frame", 11'h000, {10'h000, busy2});
  endtask
  // Back-to-back writes, then reads; bit-reversal-sensitive values expose order faults.
  task automatic t_write_read();
    host_op(1'b0, 11'h03E, 8'hB4);
    chk("write address", 11'h03E, sa);
    chk("write data", 11'h0B4, {3'h0, sd});
    host_op(1'b0, 11'h001, 8'h1E);
    chk("write data", 11'h01E, {3'h0, sd});
    host_op(1'b1, 11'h03E, 8'h00);
    chk("read data", 11'h0B4, {3'h0, q});
    host_op(1'b1, 11'h001, 8'h00);
    chk("read data", 11'h01E, {3'h0, q});
    host_op(1'b1, 11'h7FF, 8'h00);
    chk("unmapped read", 11'h000, {3'h0, q});
    chk_n("write strobes", 2, n1);
    repeat (4) @(negedge CLK);
    chk("device busy", 11'h000, {10'h000, busy});
  endtask
  // A cut frame must leave nothing; the following full frame must start afresh.
  task automatic t_abort();
    bang({5'h00, 11'h005, 8'hC6}, 20);
    chk_n("aborted strobes", 0, n2);
    bang({5'h00, 11'h005, 8'h3A}, 24);
    chk_n("write strobes", 1, n2);
    chk("write address", 11'h005, sa2);
    chk("write data", 11'h03A, {3'h0, sd2});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence: reset for five cycles, then each scenario in turn.
  initial begin
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.sdi = 1'b0;
    repeat (5) @(negedge CLK);
    RST = 1'b0;
    t_write_read();
    t_abort();
    results();
  end
  // The scenarios need about 16 us; six times that means a hang.
  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule // tb_serial_register_access_port
